// [ca_term_pkg.sv]
// constants for command/address termination control
// Behaviour
// - strength code comes from bits 6 to 4 of the config register.
// - after reset termination stays off until a valid code is written.
// - codes 001..110 select 240, 120, 80, 60, 48, 40 ohm.
// - disabled strength code forces CA, clock and select termination off.
// - select register bits 5, 3, 4 turn off CA, clock, select.
// - enable derives only from mode registers; the dedicated pin is ignored.
// - termination covers both clock pins, select and all six CA lines.
package ca_term_pkg;
	localparam int STRENGTH_MSB = 6;
	localparam int STRENGTH_LSB = 4;
	localparam int CA_DIS_BIT = 5;
	localparam int CS_DIS_BIT = 4;
	localparam int CK_DIS_BIT = 3;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [5:0] CA_EN_RESET = 6'h00;
	localparam logic       ENABLE_RESET = 1'b0;
	localparam int CA_LINES = 6;
	localparam logic [2:0] CODE_OFF = 3'h0;
	localparam logic [2:0] CODE_RSVD = 3'h7;
	localparam logic [2:0] CODE_240 = 3'h1;
	localparam logic [2:0] CODE_120 = 3'h2;
	localparam logic [2:0] CODE_80 = 3'h3;
	localparam logic [2:0] CODE_60 = 3'h4;
	localparam logic [2:0] CODE_48 = 3'h5;
	localparam logic [2:0] CODE_40 = 3'h6;
	// strength as a divider of the reference resistor
	localparam logic [2:0] DIV_NONE = 3'h0;
endpackage

// [ca_termination_control.sv]
// mode-register driven termination control for the command/address bus
`timescale 1ns/1ps
module ca_termination_control (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       configWrite,
	input  wire logic [7:0] configData,
	input  wire logic       selectWrite,
	input  wire logic [7:0] selectData,
	input  wire logic       caTerminationPin,
	output logic [7:0]      termination_config_register,
	output logic [7:0]      termination_select_register,
	output logic [5:0]      caTermEnable,
	output logic            clockTrueTermEnable,
	output logic            clockComplementTermEnable,
	output logic            selectTermEnable,
	output logic [2:0]      resistorDivider,
	output logic            strengthValid
);
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] sel;
		logic [5:0] caEn;
		logic       ckEn;
		logic       csEn;
		logic [2:0] div;
		logic       valid;
	} state_s;

	state_s stateReg;
	state_s stateNext;

	function automatic logic codeValid(input logic [2:0] code);
		codeValid = (code != ca_term_pkg::CODE_OFF) && (code != ca_term_pkg::CODE_RSVD);
	endfunction

	// a group terminates only with a valid code and its disable bit clear
	function automatic logic groupOn(input logic valid, input logic disableBit);
		groupOn = valid & ~disableBit;
	endfunction

	// divider N means reference resistor over N
	function automatic logic [2:0] codeDivider(input logic [2:0] code);
		case (code)
			ca_term_pkg::CODE_240: codeDivider = 3'h1;
			ca_term_pkg::CODE_120: codeDivider = 3'h2;
			ca_term_pkg::CODE_80:  codeDivider = 3'h3;
			ca_term_pkg::CODE_60:  codeDivider = 3'h4;
			ca_term_pkg::CODE_48:  codeDivider = 3'h5;
			ca_term_pkg::CODE_40:  codeDivider = 3'h6;
			default:               codeDivider = ca_term_pkg::DIV_NONE;
		endcase
	endfunction

	logic [2:0] nextCode;
	logic       nextValid;

	always_comb begin
		stateNext = stateReg;
		if (configWrite) begin
			stateNext.cfg = configData;
		end
		if (selectWrite) begin
			stateNext.sel = selectData;
		end
		// enables follow register contents only; the pin is not used
		nextCode = stateNext.cfg[ca_term_pkg::STRENGTH_MSB:ca_term_pkg::STRENGTH_LSB];
		nextValid = codeValid(nextCode);
		stateNext.valid = nextValid;
		stateNext.div = codeDivider(nextCode);
		stateNext.caEn = {ca_term_pkg::CA_LINES{groupOn(nextValid,
			stateNext.sel[ca_term_pkg::CA_DIS_BIT])}};
		stateNext.ckEn = groupOn(nextValid,
			stateNext.sel[ca_term_pkg::CK_DIS_BIT]);
		stateNext.csEn = groupOn(nextValid,
			stateNext.sel[ca_term_pkg::CS_DIS_BIT]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg.cfg <= ca_term_pkg::CONFIG_RESET;
			stateReg.sel <= ca_term_pkg::SELECT_RESET;
			stateReg.caEn <= ca_term_pkg::CA_EN_RESET;
			stateReg.ckEn <= ca_term_pkg::ENABLE_RESET;
			stateReg.csEn <= ca_term_pkg::ENABLE_RESET;
			stateReg.div <= ca_term_pkg::DIV_NONE;
			stateReg.valid <= ca_term_pkg::ENABLE_RESET;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign termination_config_register = stateReg.cfg;
	assign termination_select_register = stateReg.sel;
	assign caTermEnable = stateReg.caEn;
	assign clockTrueTermEnable = stateReg.ckEn;
	assign clockComplementTermEnable = stateReg.ckEn;
	assign selectTermEnable = stateReg.csEn;
	assign resistorDivider = stateReg.div;
	assign strengthValid = stateReg.valid;

	logic [2:0] curCode;
	assign curCode = stateReg.cfg[ca_term_pkg::STRENGTH_MSB:ca_term_pkg::STRENGTH_LSB];

	a_disabled_all_off: assert property (@(posedge clk) disable iff (!rst_n)
		!codeValid(curCode) |-> (caTermEnable == 6'h00 && !clockTrueTermEnable
			&& !selectTermEnable))
		else $error("termination on with disabled code");
	a_ca_follows_bit: assert property (@(posedge clk) disable iff (!rst_n)
		codeValid(curCode) |-> (caTermEnable
			== {6{~termination_select_register[ca_term_pkg::CA_DIS_BIT]}}))
		else $error("ca enable mismatch");
	a_clock_follows_bit: assert property (@(posedge clk) disable iff (!rst_n)
		codeValid(curCode) |-> (clockTrueTermEnable
			== ~termination_select_register[ca_term_pkg::CK_DIS_BIT]))
		else $error("clock enable mismatch");
	a_select_follows_bit: assert property (@(posedge clk) disable iff (!rst_n)
		codeValid(curCode) |-> (selectTermEnable
			== ~termination_select_register[ca_term_pkg::CS_DIS_BIT]))
		else $error("select enable mismatch");
	a_config_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && configWrite |=> (termination_config_register == $past(configData)))
		else $error("config write lost");
	a_pin_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		(!configWrite && !selectWrite) |=> $stable(caTermEnable) && $stable(selectTermEnable))
		else $error("enable changed without register write");
	a_clock_pair: assert property (@(posedge clk) disable iff (!rst_n)
		clockTrueTermEnable == clockComplementTermEnable)
		else $error("clock pair enables differ");
	a_divider_map: assert property (@(posedge clk) disable iff (!rst_n)
		codeValid(curCode) |-> (resistorDivider == curCode))
		else $error("strength decode wrong");
	a_reserved_off: assert property (@(posedge clk) disable iff (!rst_n)
		(curCode == ca_term_pkg::CODE_RSVD || curCode == ca_term_pkg::CODE_OFF)
			|-> (!strengthValid && resistorDivider == ca_term_pkg::DIV_NONE))
		else $error("reserved code enabled");
	a_reset_off: assert property (@(posedge clk)
		$rose(rst_n) |-> (caTermEnable == 6'h00 && !strengthValid))
		else $error("termination on after reset");

	// strength code carried by a write, for the write checks
	logic [2:0] writeCode;
	logic       writeCodeOk;
	assign writeCode = configData[ca_term_pkg::STRENGTH_MSB:ca_term_pkg::STRENGTH_LSB];
	assign writeCodeOk = (writeCode != ca_term_pkg::CODE_OFF)
		&& (writeCode != ca_term_pkg::CODE_RSVD);

	// register writes and hold
	a_select_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && selectWrite |=> (termination_select_register == $past(selectData)))
		else $error("select write lost");
	a_config_held: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !configWrite |=> $stable(termination_config_register))
		else $error("config register changed without write");
	a_select_held: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !selectWrite |=> $stable(termination_select_register))
		else $error("select register changed without write");

	// group enables
	a_ca_lines_equal: assert property (@(posedge clk) disable iff (!rst_n)
		caTermEnable == 6'h00 || caTermEnable == 6'h3f)
		else $error("ca lines enabled unevenly");
	a_complement_off: assert property (@(posedge clk) disable iff (!rst_n)
		!codeValid(curCode) |-> !clockComplementTermEnable)
		else $error("complement clock on with disabled code");
	a_complement_follows: assert property (@(posedge clk) disable iff (!rst_n)
		codeValid(curCode) |-> (clockComplementTermEnable
			== ~termination_select_register[ca_term_pkg::CK_DIS_BIT]))
		else $error("complement clock enable mismatch");
	a_enable_needs_valid: assert property (@(posedge clk) disable iff (!rst_n)
		(|caTermEnable || clockTrueTermEnable || selectTermEnable) |-> strengthValid)
		else $error("termination on without valid strength");
	a_ca_update: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && selectWrite && !configWrite && strengthValid
			|=> (caTermEnable == {6{~$past(selectData[ca_term_pkg::CA_DIS_BIT])}}))
		else $error("ca enable did not follow select write");
	a_clock_update: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && selectWrite && !configWrite && strengthValid
			|=> (clockTrueTermEnable == ~$past(selectData[ca_term_pkg::CK_DIS_BIT])))
		else $error("clock enable did not follow select write");
	a_select_update: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && selectWrite && !configWrite && strengthValid
			|=> (selectTermEnable == ~$past(selectData[ca_term_pkg::CS_DIS_BIT])))
		else $error("select enable did not follow select write");
	a_config_update: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && configWrite |=> (strengthValid == $past(writeCodeOk)))
		else $error("strength valid did not follow config write");
	a_both_writes: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && configWrite && selectWrite |=> (selectTermEnable
			== ($past(writeCodeOk) && !$past(selectData[ca_term_pkg::CS_DIS_BIT]))))
		else $error("select enable wrong after joint write");

	// strength decode
	a_valid_range: assert property (@(posedge clk) disable iff (!rst_n)
		strengthValid == (curCode >= ca_term_pkg::CODE_240 && curCode <= ca_term_pkg::CODE_40))
		else $error("strength valid outside code range");
	a_divider_zero_off: assert property (@(posedge clk) disable iff (!rst_n)
		!strengthValid |-> (resistorDivider == ca_term_pkg::DIV_NONE))
		else $error("divider set while disabled");
	a_divider_240: assert property (@(posedge clk) disable iff (!rst_n)
		curCode == ca_term_pkg::CODE_240 |-> (resistorDivider == 3'h1))
		else $error("240 ohm code decoded wrong");
	a_divider_120: assert property (@(posedge clk) disable iff (!rst_n)
		curCode == ca_term_pkg::CODE_120 |-> (resistorDivider == 3'h2))
		else $error("120 ohm code decoded wrong");
	a_divider_80: assert property (@(posedge clk) disable iff (!rst_n)
		curCode == ca_term_pkg::CODE_80 |-> (resistorDivider == 3'h3))
		else $error("80 ohm code decoded wrong");
	a_divider_60: assert property (@(posedge clk) disable iff (!rst_n)
		curCode == ca_term_pkg::CODE_60 |-> (resistorDivider == 3'h4))
		else $error("60 ohm code decoded wrong");
	a_divider_48: assert property (@(posedge clk) disable iff (!rst_n)
		curCode == ca_term_pkg::CODE_48 |-> (resistorDivider == 3'h5))
		else $error("48 ohm code decoded wrong");
	a_divider_40: assert property (@(posedge clk) disable iff (!rst_n)
		curCode == ca_term_pkg::CODE_40 |-> (resistorDivider == 3'h6))
		else $error("40 ohm code decoded wrong");

	// reset and pin
	a_pin_toggle_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && $changed(caTerminationPin) && !configWrite && !selectWrite
			|=> $stable(clockTrueTermEnable) && $stable(strengthValid))
		else $error("pin toggle changed termination");
	a_valid_rise_write: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(strengthValid) |-> $past(configWrite))
		else $error("strength valid rose without config write");
	a_reset_all_off: assert property (@(posedge clk)
		$rose(rst_n) |-> (resistorDivider == ca_term_pkg::DIV_NONE && !clockTrueTermEnable
			&& !clockComplementTermEnable && !selectTermEnable))
		else $error("group enabled after reset");
endmodule

// [mr_write_driver.sv]
// controller model issuing mode register writes
`timescale 1ns/1ps
module mr_write_driver (
	input  wire logic clk,
	output logic       configWrite,
	output logic [7:0] configData,
	output logic       selectWrite,
	output logic [7:0] selectData
);
	initial begin
		configWrite = 1'b0;
		configData = 8'h00;
		selectWrite = 1'b0;
		selectData = 8'h00;
	end
	// single rank: it terminates and is trained first
	// calibration point fixed at half supply, so every code is usable
	// one call per edge; config and select writes can be requested on the same edge
	task automatic issue(input logic cw, input logic [7:0] cd, input logic sw,
			input logic [7:0] sd);
		@(posedge clk);
		configWrite <= cw;
		configData <= cd;
		selectWrite <= sw;
		selectData <= sd;
	endtask
endmodule

// [ca_termination_control_tb_top.sv]
// self-checking bench for the termination control
`timescale 1ns/1ps
module ca_termination_control_tb_top;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       pin = 1'b0;
	logic       cw, sw, sv, ckT, ckC, csE;
	logic [7:0] cd, sd, cfgReg, selReg, cfgM = 8'h00, selM = 8'h00;
	logic [5:0] caE;
	logic [2:0] div;
	logic [31:0] r;
	int         badCount = 0;
	int         testsRun = 0;
	int         seed = 12946;
	always #25 clk = ~clk;
	mr_write_driver mr_write_driver_inst (.clk(clk), .configWrite(cw), .configData(cd),
		.selectWrite(sw), .selectData(sd));
	ca_termination_control ca_termination_control_inst (.clk(clk), .rst_n(rst_n),
		.configWrite(cw), .configData(cd), .selectWrite(sw), .selectData(sd),
		.caTerminationPin(pin), .termination_config_register(cfgReg),
		.termination_select_register(selReg), .caTermEnable(caE),
		.clockTrueTermEnable(ckT), .clockComplementTermEnable(ckC),
		.selectTermEnable(csE), .resistorDivider(div), .strengthValid(sv));
	task automatic wrapUp();
		if (badCount == 0 && testsRun > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		testsRun++;
		if (g !== e) begin
			badCount++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic checkAll();
		logic [2:0] c;
		logic       v;
		c = cfgM[6:4];
		v = (c >= 3'h1) && (c <= 3'h6);
		cmp("config", cfgM, cfgReg);
		cmp("select", selM, selReg);
		cmp("divider", v ? {5'h00, c} : 8'h00, {5'h00, div});
		cmp("valid", {7'h00, v}, {7'h00, sv});
		cmp("ca", (v && !selM[5]) ? 8'h3f : 8'h00, {2'h0, caE});
		cmp("clock", {6'h00, {2{v && !selM[3]}}}, {6'h00, ckT, ckC});
		cmp("cs", {7'h00, v && !selM[4]}, {7'h00, csE});
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		checkAll();
		for (int i = 0; i < 90; i++) begin
			r = $random(seed);
			if (i < 16) r[6:4] = i[3:1];
			r[16] = r[16] | (i < 16);
			if (i == 0) r[17:16] = 2'b10;
			if (i == 89) r[17:16] = 2'b00;
			mr_write_driver_inst.issue(r[16], r[7:0], r[17], r[15:8]);
			pin <= r[18];
			if (i == 40 || i == 41) rst_n <= (i == 41);
			@(negedge clk);
			if (i == 40) begin
				cfgM = 8'h00;
				selM = 8'h00;
			end
			checkAll();
			if (i != 40 && r[16]) cfgM = r[7:0];
			if (i != 40 && r[17]) selM = r[15:8];
		end
		@(negedge clk);
		checkAll();
		wrapUp();
	end
	initial begin
		repeat (2000) @(posedge clk);
		badCount++;
		wrapUp();
	end
endmodule
